// ---- logic/pwmdpv_pkg.sv ----
package pwmdpv_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned VAL_W  = 16;

    // word indices on the avalon slave
    localparam logic [ADDR_W-1:0] IDX_PRI_DUTY  = 3'h0;
    localparam logic [ADDR_W-1:0] IDX_SEC_DUTY  = 3'h1;
    localparam logic [ADDR_W-1:0] IDX_PHASE     = 3'h2;
    localparam logic [ADDR_W-1:0] IDX_GEN_CTRL  = 3'h3;
    localparam logic [ADDR_W-1:0] IDX_PIN_CTRL  = 3'h4;
    localparam logic [ADDR_W-1:0] IDX_STATUS    = 3'h5;

    // field positions
    localparam int unsigned ITB_BIT      = 0;
    localparam int unsigned MODE_LSB     = 10;
    localparam int unsigned MODE_MSB     = 11;
    localparam int unsigned ST_HIGH_BIT  = 0;
    localparam int unsigned ST_LOW_BIT   = 1;
    localparam int unsigned ST_PP_BIT    = 2;
    localparam int unsigned ST_CNT_LSB   = 16;

    localparam logic [VAL_W-1:0] VAL_RST      = 16'h0000;
    localparam logic [VAL_W-1:0] CNT_ONE      = 16'h0001;
    // duty limits: narrowest and margin from the period
    localparam logic [VAL_W-1:0] DUTY_MIN     = 16'h0009;
    localparam logic [VAL_W-1:0] DUTY_MARGIN  = 16'h0008;
    // smallest independent period accepted
    localparam logic [VAL_W-1:0] IND_PER_MIN  = 16'h0008;

    localparam int unsigned CLK_MHZ   = 200;
    // band near 0 % and 100 % where resolution may coarsen
    localparam int unsigned EDGE_NS   = 40;
    localparam int unsigned EDGE_CYC  = (EDGE_NS * CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        MODE_COMP = 2'b00,
        MODE_RED  = 2'b01,
        MODE_PP   = 2'b10,
        MODE_IND  = 2'b11
    } pwmdpv_mode_t;

endpackage : pwmdpv_pkg

// ---- logic/pwmdpv_gen.sv ----
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - primary duty register, 16 bits, resets zero
// - independent mode: primary duty drives high side
// - other modes: primary duty drives both sides
// - duty pulse limited to 9 .. period-8
// - near 0/100 % resolution may coarsen
// - secondary duty register, 16 bits, resets zero
// - secondary duty used only in independent mode
// - phase register: shift or period, resets zero
// - select 0, modes 00-10: shift both outputs
// - select 0, mode 11: shift low side only
// - select 1, modes 00-10: period both outputs
// - select 1, mode 11: period low side only
// - independent period pulse limited 9 .. per-8
// - mode code at bits 11:10 of pin control
module pwmdpv_gen (
    input  wire logic                             mclk,
    input  wire logic                             rst_n,
    input  wire logic [pwmdpv_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [pwmdpv_pkg::DATA_W-1:0]    avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic      [pwmdpv_pkg::DATA_W-1:0]    avs_readdata,
    output logic                                  avs_waitrequest,
    input  wire logic [pwmdpv_pkg::VAL_W-1:0]     master_period,
    output logic                                  high_side_output,
    output logic                                  low_side_output
);
    import pwmdpv_pkg::*;

    logic [VAL_W-1:0]  primary_duty_value_r;
    logic [VAL_W-1:0]  secondary_duty_value_r;
    logic [VAL_W-1:0]  phase_or_period_value_r;
    logic              independent_time_base_select_r;
    logic [VAL_W-1:0]  output_pin_control_r;
    pwmdpv_mode_t      output_mode_code;
    logic              ack_r;
    logic              req;
    logic              wr_go;
    logic [VAL_W-1:0]  wr_val;
    logic [VAL_W-1:0]  mst_cnt_r;
    logic [VAL_W-1:0]  ind_cnt_r;
    logic [VAL_W-1:0]  ind_per;
    logic              pp_odd_r;
    logic [VAL_W:0]    shift_sum;
    logic [VAL_W-1:0]  shifted_cnt;
    logic [VAL_W-1:0]  hi_cnt;
    logic [VAL_W-1:0]  lo_cnt;
    logic [VAL_W-1:0]  hi_per;
    logic [VAL_W-1:0]  lo_per;
    logic [VAL_W-1:0]  hi_duty;
    logic [VAL_W-1:0]  lo_duty;
    logic              hi_on;
    logic              lo_on;
    logic              is_ind;

    // ---------------- avalon slave ----------------
    // one wait state on every access: read data is registered
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go           = avs_write & ~avs_waitrequest;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // only the low two byte lanes carry state
    always_comb begin
        wr_val = VAL_RST;
        case (avs_address)
            IDX_PRI_DUTY: wr_val = primary_duty_value_r;
            IDX_SEC_DUTY: wr_val = secondary_duty_value_r;
            IDX_PHASE:    wr_val = phase_or_period_value_r;
            IDX_PIN_CTRL: wr_val = output_pin_control_r;
            default:      wr_val = VAL_RST;
        endcase
        if (avs_byteenable[0]) begin
            wr_val[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            wr_val[15:8] = avs_writedata[15:8];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            primary_duty_value_r <= VAL_RST;
        end else if (wr_go && avs_address == IDX_PRI_DUTY) begin
            primary_duty_value_r <= wr_val;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            secondary_duty_value_r <= VAL_RST;
        end else if (wr_go && avs_address == IDX_SEC_DUTY) begin
            secondary_duty_value_r <= wr_val;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_or_period_value_r <= VAL_RST;
        end else if (wr_go && avs_address == IDX_PHASE) begin
            phase_or_period_value_r <= wr_val;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            independent_time_base_select_r <= 1'b0;
            output_pin_control_r           <= VAL_RST;
        end else if (wr_go) begin
            if (avs_address == IDX_GEN_CTRL && avs_byteenable[0]) begin
                independent_time_base_select_r <= avs_writedata[ITB_BIT];
            end
            if (avs_address == IDX_PIN_CTRL) begin
                output_pin_control_r <= wr_val;
            end
        end
    end

    assign output_mode_code =
        pwmdpv_mode_t'(output_pin_control_r[MODE_MSB:MODE_LSB]);
    assign is_ind = (output_mode_code == MODE_IND);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= '0;
            case (avs_address)
                IDX_PRI_DUTY: avs_readdata[VAL_W-1:0] <= primary_duty_value_r;
                IDX_SEC_DUTY:
                    avs_readdata[VAL_W-1:0] <= secondary_duty_value_r;
                IDX_PHASE:
                    avs_readdata[VAL_W-1:0] <= phase_or_period_value_r;
                IDX_GEN_CTRL:
                    avs_readdata[ITB_BIT] <= independent_time_base_select_r;
                IDX_PIN_CTRL: avs_readdata[VAL_W-1:0] <= output_pin_control_r;
                IDX_STATUS: begin
                    avs_readdata[ST_HIGH_BIT] <= high_side_output;
                    avs_readdata[ST_LOW_BIT]  <= low_side_output;
                    avs_readdata[ST_PP_BIT]   <= pp_odd_r;
                    avs_readdata[DATA_W-1:ST_CNT_LSB] <= mst_cnt_r;
                end
                default: avs_readdata <= '0;
            endcase
        end
    end

    // ---------------- time bases ----------------
    // independent period floored so a tiny value cannot stall the count
    assign ind_per = (phase_or_period_value_r < IND_PER_MIN) ?
                     IND_PER_MIN : phase_or_period_value_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mst_cnt_r <= VAL_RST;
            pp_odd_r  <= 1'b0;
        end else if (mst_cnt_r + CNT_ONE >= master_period) begin
            mst_cnt_r <= VAL_RST;
            pp_odd_r  <= ~pp_odd_r;
        end else begin
            mst_cnt_r <= mst_cnt_r + CNT_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ind_cnt_r <= VAL_RST;
        end else if (ind_cnt_r + CNT_ONE >= ind_per) begin
            ind_cnt_r <= VAL_RST;
        end else begin
            ind_cnt_r <= ind_cnt_r + CNT_ONE;
        end
    end

    // phase shift wraps inside the master period
    assign shift_sum = {1'b0, mst_cnt_r} + {1'b0, phase_or_period_value_r};
    assign shifted_cnt = (shift_sum >= {1'b0, master_period}) ?
        VAL_W'(shift_sum - {1'b0, master_period}) : shift_sum[VAL_W-1:0];

    always_comb begin
        hi_cnt = mst_cnt_r;
        lo_cnt = mst_cnt_r;
        hi_per = master_period;
        lo_per = master_period;
        if (!independent_time_base_select_r) begin
            lo_cnt = shifted_cnt;
            if (!is_ind) begin
                hi_cnt = shifted_cnt;
            end
        end else begin
            lo_cnt = ind_cnt_r;
            lo_per = ind_per;
            if (!is_ind) begin
                hi_cnt = ind_cnt_r;
                hi_per = ind_per;
            end
        end
    end

    // clamp to the pulse limits; below 9 the pulse is dropped and above period-8
    // it is held at period-8, which the coarser allowance near 0/100 % permits
    function automatic logic [VAL_W-1:0] clamp_duty(
        input logic [VAL_W-1:0] d,
        input logic [VAL_W-1:0] per
    );
        logic [VAL_W-1:0] top;
        top = (per > DUTY_MARGIN) ? VAL_W'(per - DUTY_MARGIN) : VAL_RST;
        if (d < DUTY_MIN) begin
            clamp_duty = VAL_RST;
        end else if (d > top) begin
            clamp_duty = top;
        end else begin
            clamp_duty = d;
        end
    endfunction : clamp_duty

    assign hi_duty = clamp_duty(primary_duty_value_r,
                                hi_per);
    assign lo_duty = is_ind ?
        clamp_duty(secondary_duty_value_r, lo_per) :
        clamp_duty(primary_duty_value_r, lo_per);

    assign hi_on = (hi_cnt < hi_duty);
    assign lo_on = (lo_cnt < lo_duty);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            high_side_output <= 1'b0;
            low_side_output  <= 1'b0;
        end else begin
            unique case (output_mode_code)
                MODE_COMP: begin
                    high_side_output <= hi_on;
                    low_side_output  <= ~lo_on;
                end
                MODE_RED: begin
                    high_side_output <= hi_on;
                    low_side_output  <= lo_on;
                end
                MODE_PP: begin
                    high_side_output <= hi_on & ~pp_odd_r;
                    low_side_output  <= lo_on & pp_odd_r;
                end
                MODE_IND: begin
                    high_side_output <= hi_on;
                    low_side_output  <= lo_on;
                end
            endcase
        end
    end

    // ---------------- assertions ----------------
    a_wait_one_cycle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("access not answered after one wait state");

    a_pri_write_lands: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_go && avs_address == IDX_PRI_DUTY && avs_byteenable[1:0] == 2'b11
        |=> primary_duty_value_r == $past(avs_writedata[15:0]))
        else $error("primary duty write lost");

    a_sec_write_lands: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_go && avs_address == IDX_SEC_DUTY && avs_byteenable[1:0] == 2'b11
        |=> secondary_duty_value_r == $past(avs_writedata[15:0]))
        else $error("secondary duty write lost");

    a_phase_reads_back: assert property (
        @(posedge mclk) disable iff (!rst_n)
        avs_read && !ack_r && avs_address == IDX_PHASE && !wr_go
        |=> avs_readdata == {16'h0000, $past(phase_or_period_value_r)})
        else $error("phase value read back wrong");

    a_short_duty_low: assert property (
        @(posedge mclk) disable iff (!rst_n)
        primary_duty_value_r < DUTY_MIN && !is_ind
        |=> !$past(hi_on) && !high_side_output)
        else $error("duty below minimum produced a pulse");

    a_ind_low_secondary: assert property (
        @(posedge mclk) disable iff (!rst_n)
        is_ind && secondary_duty_value_r < DUTY_MIN |=> !low_side_output)
        else $error("independent low side not using secondary duty");

    a_grp_low_primary: assert property (
        @(posedge mclk) disable iff (!rst_n)
        output_mode_code == MODE_COMP && primary_duty_value_r < DUTY_MIN
        |=> low_side_output)
        else $error("low side not using primary duty");

    a_ind_hi_unshifted: assert property (
        @(posedge mclk) disable iff (!rst_n)
        is_ind && !independent_time_base_select_r |-> hi_cnt == mst_cnt_r)
        else $error("high side shifted in independent mode");

    a_ind_per_floor: assert property (
        @(posedge mclk) disable iff (!rst_n)
        independent_time_base_select_r && $stable(phase_or_period_value_r)
        |-> ind_cnt_r < ind_per && ind_per >= IND_PER_MIN)
        else $error("independent counter outside its period");

    a_itb_low_counter: assert property (
        @(posedge mclk) disable iff (!rst_n)
        independent_time_base_select_r |-> lo_cnt == ind_cnt_r
        && (is_ind ? hi_cnt == mst_cnt_r : hi_cnt == ind_cnt_r))
        else $error("time base routing wrong");

    a_redundant_equal: assert property (
        @(posedge mclk) disable iff (!rst_n)
        output_mode_code == MODE_RED && $stable(output_mode_code)
        && !independent_time_base_select_r
        && $stable(independent_time_base_select_r)
        |=> high_side_output == low_side_output)
        else $error("redundant outputs differ");

    a_duty_top_clamp: assert property (
        @(posedge mclk) disable iff (!rst_n)
        hi_per > DUTY_MARGIN |-> hi_duty <= hi_per - DUTY_MARGIN)
        else $error("duty above the period margin");

    a_pp_never_both: assert property (
        @(posedge mclk) disable iff (!rst_n)
        output_mode_code == MODE_PP
        |=> !(high_side_output && low_side_output))
        else $error("push-pull drove both sides");

    a_comp_opposite: assert property (
        @(posedge mclk) disable iff (!rst_n)
        output_mode_code == MODE_COMP
        |=> high_side_output != low_side_output)
        else $error("complementary outputs not opposite");

    a_shift_both_sides: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !independent_time_base_select_r && !is_ind |-> hi_cnt == lo_cnt)
        else $error("group modes shift the sides differently");

endmodule : pwmdpv_gen

// ---- tb/pwmdpv_stage.sv ----
`timescale 1ns/10ps
// power stage model: tallies conduction time of each switch and of
// both at once, so duty, clamping and phase show up as plain counts
module pwmdpv_stage (
    input  wire logic        mclk,
    input  wire logic        clr,
    input  wire logic        high_side_output,
    input  wire logic        low_side_output,
    output logic      [15:0] high_cnt,
    output logic      [15:0] low_cnt,
    output logic      [15:0] both_cnt
);
    always_ff @(posedge mclk) begin
        if (clr) begin
            high_cnt <= 16'h0000;
            low_cnt  <= 16'h0000;
            both_cnt <= 16'h0000;
        end else begin
            high_cnt <= high_cnt + 16'(high_side_output);
            low_cnt  <= low_cnt + 16'(low_side_output);
            both_cnt <= both_cnt + 16'(high_side_output & low_side_output);
        end
    end
endmodule : pwmdpv_stage

// ---- tb/pwm_duty_phase_values_tb.sv ----
`timescale 1ns/10ps
module pwm_duty_phase_values_tb;
    import pwmdpv_pkg::*;
    typedef struct packed {
        logic [1:0]  mode;
        logic        independent_time_base_select;
        logic [15:0] pri, sec, pha, ehi, elo, eov;
    } pwmdpv_row_t;

    logic              mclk, rst_n, avs_read, avs_write, clr;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
    logic [3:0]        avs_byteenable;
    logic              avs_waitrequest, high_side_output, low_side_output;
    logic [VAL_W-1:0]  master_period, high_cnt, low_cnt, both_cnt;
    int                miscompares, samples_checked;
    pwmdpv_row_t       rows [11];

    pwmdpv_gen i_pwmdpv_gen (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .master_period(master_period),
        .high_side_output(high_side_output),
        .low_side_output(low_side_output)
    );
    pwmdpv_stage i_pwmdpv_stage (
        .mclk(mclk), .clr(clr), .high_side_output(high_side_output),
        .low_side_output(low_side_output), .high_cnt(high_cnt),
        .low_cnt(low_cnt), .both_cnt(both_cnt)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // request held until waitrequest is sampled low at a rising edge;
    // read data is taken at that same edge, then the request drops
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        if (n == 20) chk("bus answer", 32'h0000_0000, 32'h0000_0001);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; clr = 1'b0;
        avs_address = 3'h0; avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF; master_period = 16'h0028;
        miscompares = 0; samples_checked = 0;
        rows = '{
            {2'b00, 1'b0, 16'h0014, 16'h0005, 16'h0000,
             16'h0028, 16'h0028, 16'h0000},
            {2'b01, 1'b0, 16'h000C, 16'h0000, 16'h0000,
             16'h0018, 16'h0018, 16'h0018},
            {2'b10, 1'b0, 16'h000F, 16'h0000, 16'h0000,
             16'h000F, 16'h000F, 16'h0000},
            {2'b11, 1'b0, 16'h0014, 16'h000C, 16'h0000,
             16'h0028, 16'h0018, 16'h0018},
            {2'b11, 1'b0, 16'h0014, 16'h0014, 16'h000A,
             16'h0028, 16'h0028, 16'h0014},
            {2'b00, 1'b0, 16'h000A, 16'h0000, 16'h000A,
             16'h0014, 16'h003C, 16'h0000},
            {2'b00, 1'b0, 16'h0008, 16'h0000, 16'h0000,
             16'h0000, 16'h0050, 16'h0000},
            {2'b00, 1'b0, 16'h0009, 16'h0000, 16'h0000,
             16'h0012, 16'h003E, 16'h0000},
            {2'b00, 1'b0, 16'h0023, 16'h0000, 16'h0000,
             16'h0040, 16'h0010, 16'h0000},
            {2'b01, 1'b1, 16'h000F, 16'h0000, 16'h0014,
             16'h0030, 16'h0030, 16'h0030},
            {2'b11, 1'b1, 16'h000A, 16'h000F, 16'h0014,
             16'h0014, 16'h0030, 16'hFFFF}};
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, ADDR_W'(i), 32'h0000_0000, 4'hF, q);
            chk("value reset", q, 32'h0000_0000);
        end
        bus(1'b1, IDX_PRI_DUTY, 32'hFFFF_A5C3, 4'b0001, q);
        bus(1'b0, IDX_PRI_DUTY, 32'h0000_0000, 4'hF, q);
        chk("primary lane", q, 32'h0000_00C3);
        bus(1'b1, IDX_SEC_DUTY, 32'hFFFF_1234, 4'hF, q);
        bus(1'b0, IDX_SEC_DUTY, 32'h0000_0000, 4'hF, q);
        chk("secondary rw", q, 32'h0000_1234);
        bus(1'b1, IDX_PIN_CTRL, 32'h0000_0C00, 4'hF, q);
        bus(1'b0, IDX_PIN_CTRL, 32'h0000_0000, 4'hF, q);
        chk("mode field", q, 32'h0000_0C00);
        bus(1'b1, 3'h7, 32'h0000_FFFF, 4'hF, q);
        bus(1'b0, 3'h7, 32'h0000_0000, 4'hF, q);
        chk("unmapped", q, 32'h0000_0000);
        // whole window of two master periods makes counts phase-free
        foreach (rows[i]) begin
            bus(1'b1, IDX_PIN_CTRL,
                {20'h0_0000, rows[i].mode, 10'h000}, 4'hF, q);
            bus(1'b1, IDX_GEN_CTRL, {31'h0000_0000, rows[i].independent_time_base_select}, 4'hF, q);
            bus(1'b1, IDX_PRI_DUTY, {16'h0000, rows[i].pri}, 4'hF, q);
            bus(1'b1, IDX_SEC_DUTY, {16'h0000, rows[i].sec}, 4'hF, q);
            bus(1'b1, IDX_PHASE, {16'h0000, rows[i].pha}, 4'hF, q);
            repeat (120) @(posedge mclk);
            clr <= 1'b1;
            @(posedge mclk);
            clr <= 1'b0;
            repeat (80) @(posedge mclk);
            @(negedge mclk);
            chk("high time", {16'h0000, high_cnt},
                {16'h0000, rows[i].ehi});
            chk("low time", {16'h0000, low_cnt},
                {16'h0000, rows[i].elo});
            if (rows[i].eov !== 16'hFFFF) begin
                chk("overlap", {16'h0000, both_cnt},
                    {16'h0000, rows[i].eov});
            end
        end
        bus(1'b0, IDX_GEN_CTRL, 32'h0000_0000, 4'hF, q);
        chk("select bit", q, 32'h0000_0001);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("outputs in reset", {30'h0000_0000, high_side_output,
            low_side_output}, 32'h0000_0000);
        @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, IDX_PHASE, 32'h0000_0000, 4'hF, q);
        chk("phase after reset", q, 32'h0000_0000);
        bus(1'b0, IDX_PRI_DUTY, 32'h0000_0000, 4'hF, q);
        chk("duty after reset", q, 32'h0000_0000);
        bus(1'b0, IDX_SEC_DUTY, 32'h0000_0000, 4'hF, q);
        chk("secondary after reset", q, 32'h0000_0000);
        report_and_stop();
    end
endmodule : pwm_duty_phase_values_tb
